// *** hw/crc32c_word.sv ***
`timescale 1ns/10ps
module crc32c_word (
  input wire logic [31:0] crc_in,
  input wire logic [31:0] data_in,
  output logic [31:0] crc_out
);
  import ecc_crc_pkg::*;

  // one 32-bit word, msb first, non-reflected
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 31; i >= 0; i--) begin
      if (c[31] ^ data_in[i]) begin
        c = {c[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule : crc32c_word

// *** hw/ecc_crc_cmd_unit.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - a triple error sets status bit 4; it stays until the clear command.
// - the 16-bit count adds one per triple error; reset and clear zero it.
// - at 0xFFFF the count stops and ignores further detections.
// - deep power-down discards the count; it reads zero afterwards.
// - the count is read-only, volatile, sixteen bits, zero after reset.
// - the trap keeps only the first failing unit address since clear or reset.
// - deep power-down discards the trap; it reads all zeros afterwards.
// - count and trap are read only through the read-any-register path.
// - 0x19 is unit query, 0x1B is clear; single, dual, quad lanes, SDR.
// - query carries three address bytes; the three low bits are ignored.
// - dummy cycles set by the latency code follow the query address.
// - one status byte is shifted out; further clocks give junk data.
// - status byte bit 3 flags a unit triple error; other bits are zero.
// - clear takes no address, wipes flag, trap, count, needs no write enable.
// - the checksum covers only the main array, never special sector or registers.
// - 0x5B compute, 0x75 suspend, 0x7A resume, any lane mode, SDR.
// - end below start plus three aborts the checksum and sets the abort bit.
// - work in progress is high while the checksum runs, low when done.
// - Castagnoli checksum; the result starts at zero on start and reset.
// - suspended bit is set while suspended; resume is ignored otherwise.
module ecc_crc_cmd_unit (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  input wire logic [1:0] lane_mode,
  input wire logic [3:0] memory_latency_code,
  input wire logic dpd_active,
  input wire logic err_detect,
  input wire logic [ecc_crc_pkg::ADDR_W-1:0] err_unit_addr,
  output logic [ecc_crc_pkg::ARRAY_AW-1:0] unit_query_addr,
  input wire logic unit_query_err,
  output logic mem_rd_en,
  output logic [ecc_crc_pkg::ARRAY_AW-1:0] mem_rd_addr,
  input wire logic [31:0] mem_rd_data,
  output logic [7:0] ecc_status_reg,
  output logic [15:0] error_detect_count,
  output logic [31:0] first_error_address,
  output logic work_in_progress,
  output logic checksum_abort_bit,
  output logic checksum_suspended_bit,
  output logic [31:0] checksum_result_reg
);
  import ecc_crc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [CNT_W-1:0] lanes_of(input logic [1:0] mode);
    case (mode)
      LANE_DUAL: lanes_of = 7'h02;
      LANE_QUAD: lanes_of = 7'h04;
      default: lanes_of = 7'h01;
    endcase
  endfunction : lanes_of

  function automatic logic [RX_W-1:0] shift_in(input logic [RX_W-1:0] r,
                                               input logic [3:0] io,
                                               input logic [1:0] mode);
    case (mode)
      LANE_DUAL: shift_in = {r[RX_W-3:0], io[1:0]};
      LANE_QUAD: shift_in = {r[RX_W-5:0], io[3:0]};
      default: shift_in = {r[RX_W-2:0], io[0]};
    endcase
  endfunction : shift_in

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finding

  logic sck_s1, sck_s2, sck_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic [3:0] io_s1, io_s2;

  // the first stage is read only by the second stage
  always_ff @(posedge ref_clk) begin
    sck_s1 <= sck_pin;
    sck_s2 <= sck_s1;
    sck_s3 <= sck_s2;
    cs_s1 <= cs_n_pin;
    cs_s2 <= cs_s1;
    cs_s3 <= cs_s2;
    io_s1 <= io_in;
    io_s2 <= io_s1;
  end

  logic sck_rise, sck_fall, cs_rise, selected;
  assign selected = !cs_s2 && !cs_s3;
  assign sck_rise = selected && sck_s2 && !sck_s3;
  assign sck_fall = selected && !sck_s2 && sck_s3;
  assign cs_rise = cs_s2 && !cs_s3;

  ////////////////////////////////////////////////////////////////////////////////
  // command framing

  spi_state_t spi_reg;
  logic [RX_W-1:0] rx_reg, rx_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] op_reg;
  logic [3:0] dummy_reg;
  logic [7:0] tx_reg;
  logic tx_loaded_reg;
  logic [ADDR_W-1:0] sa_reg, ea_reg;
  logic exec_clear, exec_start, exec_suspend, exec_resume;

  assign rx_next = shift_in(rx_reg, io_s2, lane_mode);
  assign cnt_next = cnt_reg + lanes_of(lane_mode);

  always_ff @(posedge ref_clk) begin
    if (reset || cs_s2) begin
      spi_reg <= SPI_IDLE;
      rx_reg <= '0;
      cnt_reg <= '0;
      tx_loaded_reg <= 1'b0;
    end else if (spi_reg == SPI_IDLE) begin
      spi_reg <= SPI_RX;
    end else if (sck_rise) begin
      case (spi_reg)
        SPI_RX: begin
          rx_reg <= rx_next;
          cnt_reg <= cnt_next;
          if (cnt_next == OPCODE_BITS) begin
            case (rx_next[7:0])
              OP_UNIT_QUERY, OP_CSUM_COMPUTE: spi_reg <= SPI_RX;
              OP_ECC_CLEAR, OP_CSUM_SUSPEND, OP_CSUM_RESUME: spi_reg <= SPI_HOLD;
              default: spi_reg <= SPI_IGNORE;
            endcase
          end else if (op_reg == OP_UNIT_QUERY && cnt_next == QUERY_BITS) begin
            // low three address bits dropped: whole unit selected
            spi_reg <= (memory_latency_code == 4'h0) ? SPI_DATA : SPI_DUMMY;
          end else if (op_reg == OP_CSUM_COMPUTE && cnt_next == CSUM_BITS) begin
            spi_reg <= SPI_HOLD;
          end
        end
        SPI_DUMMY: begin
          if (dummy_reg == 4'h1) begin
            spi_reg <= SPI_DATA;
          end
        end
        SPI_HOLD: spi_reg <= SPI_IGNORE;
        default: spi_reg <= spi_reg;
      endcase
    end else if (sck_fall && spi_reg == SPI_DATA) begin
      tx_loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      op_reg <= 8'h00;
      dummy_reg <= 4'h0;
      unit_query_addr <= '0;
      sa_reg <= '0;
      ea_reg <= '0;
    end else if (sck_rise && spi_reg == SPI_RX) begin
      if (cnt_next == OPCODE_BITS) begin
        op_reg <= rx_next[7:0];
      end
      if (op_reg == OP_UNIT_QUERY && cnt_next == QUERY_BITS) begin
        unit_query_addr <= {rx_next[ARRAY_AW-1:UNIT_LSBS], {UNIT_LSBS{1'b0}}};
        dummy_reg <= memory_latency_code;
      end
      if (op_reg == OP_CSUM_COMPUTE && cnt_next == CSUM_BITS) begin
        sa_reg <= rx_next[2*ADDR_W-1:ADDR_W];
        ea_reg <= rx_next[ADDR_W-1:0];
      end
    end else if (sck_rise && spi_reg == SPI_DUMMY) begin
      dummy_reg <= dummy_reg - 4'h1;
    end
  end

  // output lanes change on the falling edge so the host samples on the rising one
  always_ff @(posedge ref_clk) begin
    if (reset || cs_s2) begin
      io_oe_n <= 4'hF;
      io_out <= 4'h0;
      tx_reg <= STATUS_ZERO;
    end else if (sck_fall && spi_reg == SPI_DATA) begin
      logic [7:0] b;
      b = tx_loaded_reg ? tx_reg : STATUS_ZERO;
      if (!tx_loaded_reg) begin
        b[UNIT_ERR_BIT] = unit_query_err;
      end
      // once the byte is gone zeros follow, which the host must treat as junk
      case (lane_mode)
        LANE_DUAL: begin
          io_out <= {2'b00, b[7:6]};
          io_oe_n <= 4'hC;
          tx_reg <= {b[5:0], 2'b00};
        end
        LANE_QUAD: begin
          io_out <= b[7:4];
          io_oe_n <= 4'h0;
          tx_reg <= {b[3:0], 4'h0};
        end
        default: begin
          io_out <= {2'b00, b[7], 1'b0};
          io_oe_n <= 4'hD;
          tx_reg <= {b[6:0], 1'b0};
        end
      endcase
    end
  end

  // commands take effect only when the frame closes on the exact bit count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      exec_clear <= 1'b0;
      exec_start <= 1'b0;
      exec_suspend <= 1'b0;
      exec_resume <= 1'b0;
    end else begin
      exec_clear <= cs_rise && spi_reg == SPI_HOLD && op_reg == OP_ECC_CLEAR;
      exec_start <= cs_rise && spi_reg == SPI_HOLD && op_reg == OP_CSUM_COMPUTE;
      exec_suspend <= cs_rise && spi_reg == SPI_HOLD && op_reg == OP_CSUM_SUSPEND;
      exec_resume <= cs_rise && spi_reg == SPI_HOLD && op_reg == OP_CSUM_RESUME;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // error tracking, exposed for the read-any-register path

  logic trap_valid_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ecc_status_reg <= STATUS_ZERO;
    end else if (err_detect) begin
      ecc_status_reg[TRIPLE_ERR_BIT] <= 1'b1;
    end else if (exec_clear) begin
      ecc_status_reg <= STATUS_ZERO;
    end
  end

  // a detection in the clearing cycle survives as the first of a new run
  always_ff @(posedge ref_clk) begin
    if (reset || dpd_active) begin
      error_detect_count <= COUNT_RESET;
      first_error_address <= TRAP_RESET;
      trap_valid_reg <= 1'b0;
    end else begin
      if (exec_clear) begin
        error_detect_count <= COUNT_RESET;
        first_error_address <= TRAP_RESET;
        trap_valid_reg <= 1'b0;
      end
      if (err_detect) begin
        if (exec_clear) begin
          error_detect_count <= COUNT_STEP;
        end else if (error_detect_count != COUNT_MAX) begin
          error_detect_count <= error_detect_count + COUNT_STEP;
        end
        if (!trap_valid_reg || exec_clear) begin
          first_error_address <= {8'h00, err_unit_addr};
          trap_valid_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checksum engine

  crc_state_t crc_reg;
  logic [ADDR_W-1:0] crc_addr_reg;
  logic suspend_pend_reg;
  logic [31:0] crc_step;
  logic [24:0] next_addr;
  logic range_bad;

  assign range_bad = {1'b0, ea_reg} < ({1'b0, sa_reg} + RANGE_SPAN);
  assign next_addr = {1'b0, crc_addr_reg} + WORD_STEP;

  crc32c_word u_step (
    .crc_in(checksum_result_reg),
    .data_in({mem_rd_data[7:0], mem_rd_data[15:8], mem_rd_data[23:16], mem_rd_data[31:24]}),
    .crc_out(crc_step)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      crc_reg <= CRC_IDLE;
      crc_addr_reg <= '0;
      suspend_pend_reg <= 1'b0;
      mem_rd_en <= 1'b0;
      mem_rd_addr <= '0;
      work_in_progress <= 1'b0;
      checksum_abort_bit <= 1'b0;
      checksum_suspended_bit <= 1'b0;
      checksum_result_reg <= CRC_INIT;
    end else begin
      mem_rd_en <= 1'b0;
      case (crc_reg)
        CRC_IDLE: begin
          if (exec_start && range_bad) begin
            checksum_abort_bit <= 1'b1;
          end else if (exec_start) begin
            checksum_abort_bit <= 1'b0;
            checksum_result_reg <= CRC_INIT;
            crc_addr_reg <= sa_reg;
            work_in_progress <= 1'b1;
            suspend_pend_reg <= 1'b0;
            crc_reg <= CRC_FETCH;
          end
        end
        CRC_FETCH: begin
          // only array address bits leave the block, so nothing else is summed
          mem_rd_en <= 1'b1;
          mem_rd_addr <= crc_addr_reg[ARRAY_AW-1:0];
          crc_reg <= CRC_ACCUM;
          if (exec_suspend) begin
            suspend_pend_reg <= 1'b1;
          end
        end
        CRC_ACCUM: begin
          checksum_result_reg <= crc_step;
          crc_addr_reg <= next_addr[ADDR_W-1:0];
          if (next_addr + RANGE_SPAN > {1'b0, ea_reg}) begin
            work_in_progress <= 1'b0;
            crc_reg <= CRC_IDLE;
          end else if (suspend_pend_reg || exec_suspend) begin
            work_in_progress <= 1'b0;
            checksum_suspended_bit <= 1'b1;
            crc_reg <= CRC_HALT;
          end else begin
            crc_reg <= CRC_FETCH;
          end
          suspend_pend_reg <= 1'b0;
        end
        CRC_HALT: begin
          if (exec_resume) begin
            checksum_suspended_bit <= 1'b0;
            work_in_progress <= 1'b1;
            crc_reg <= CRC_FETCH;
          end
        end
        default: crc_reg <= CRC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence frame_close;
    !cs_s3 ##1 cs_s3;
  endsequence
  sequence good_start;
    exec_start && crc_reg == CRC_IDLE && !range_bad;
  endsequence
  sequence bad_start;
    exec_start && crc_reg == CRC_IDLE && range_bad;
  endsequence

  AST_FLAG_SET: assert property (err_detect |=> ecc_status_reg[TRIPLE_ERR_BIT])
    else $error("triple error did not set the flag");
  AST_FLAG_CLEAR: assert property (exec_clear && !err_detect |=> ecc_status_reg == STATUS_ZERO)
    else $error("clear left the flag set");
  AST_COUNT_INC: assert property (err_detect && !exec_clear && !dpd_active
      && error_detect_count != COUNT_MAX |=> error_detect_count == $past(error_detect_count) + COUNT_STEP)
    else $error("count did not step");
  AST_COUNT_SAT: assert property (error_detect_count == COUNT_MAX && !exec_clear && !dpd_active
      |=> error_detect_count == COUNT_MAX)
    else $error("saturated count moved");
  AST_DPD_ZERO: assert property (dpd_active |=> error_detect_count == COUNT_RESET
      && first_error_address == TRAP_RESET)
    else $error("power-down did not discard count and trap");
  AST_TRAP_HOLD: assert property (trap_valid_reg && !exec_clear && !dpd_active
      |=> $stable(first_error_address))
    else $error("trap overwritten by a later error");
  AST_QUERY_ALIGN: assert property (unit_query_addr[UNIT_LSBS-1:0] == '0)
    else $error("unit address low bits not ignored");
  AST_BUS_RELEASE: assert property (frame_close |-> io_oe_n == 4'hF)
    else $error("lanes still driven after chip select rise");
  AST_ABORT: assert property (bad_start |=> checksum_abort_bit && !work_in_progress
      && crc_reg == CRC_IDLE)
    else $error("short range did not abort");
  AST_START: assert property (good_start |=> work_in_progress
      && checksum_result_reg == CRC_INIT ##1 mem_rd_en)
    else $error("checksum start malformed");
  AST_RESUME_IGNORED: assert property (exec_resume && !checksum_suspended_bit
      |=> !checksum_suspended_bit && crc_reg != CRC_HALT)
    else $error("resume acted without suspension");
endmodule : ecc_crc_cmd_unit

// *** hw/ecc_crc_pkg.sv ***
package ecc_crc_pkg;
  // opcodes
  localparam logic [7:0] OP_UNIT_QUERY = 8'h19;
  localparam logic [7:0] OP_ECC_CLEAR = 8'h1B;
  localparam logic [7:0] OP_CSUM_COMPUTE = 8'h5B;
  localparam logic [7:0] OP_CSUM_SUSPEND = 8'h75;
  localparam logic [7:0] OP_CSUM_RESUME = 8'h7A;
  // frame lengths in bits, opcode included
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] OPCODE_BITS = 7'h08;
  localparam logic [CNT_W-1:0] QUERY_BITS = 7'h20;
  localparam logic [CNT_W-1:0] CSUM_BITS = 7'h38;
  localparam int RX_W = 56;
  // protocol lane modes
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;
  localparam logic [1:0] LANE_QUAD = 2'h2;
  // status fields
  localparam int TRIPLE_ERR_BIT = 4;
  localparam int UNIT_ERR_BIT = 3;
  localparam logic [7:0] STATUS_ZERO = 8'h00;
  // counter and trap
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [31:0] TRAP_RESET = 32'h0000_0000;
  localparam int UNIT_LSBS = 3;
  // array and checksum
  localparam int ADDR_W = 24;
  localparam int ARRAY_AW = 21;
  localparam logic [24:0] RANGE_SPAN = 25'h000_0003;
  localparam logic [24:0] WORD_STEP = 25'h000_0004;
  localparam logic [31:0] CRC_POLY = 32'h1EDC_6F41;
  localparam logic [31:0] CRC_INIT = 32'h0000_0000;

  typedef enum logic [2:0] {
    SPI_IDLE, SPI_RX, SPI_DUMMY, SPI_DATA, SPI_HOLD, SPI_IGNORE
  } spi_state_t;

  typedef enum logic [1:0] {CRC_IDLE, CRC_FETCH, CRC_ACCUM, CRC_HALT} crc_state_t;
endpackage : ecc_crc_pkg

// *** verif/spi_host_model.sv ***
`timescale 1ns/10ps
module spi_host_model (
  input wire logic ref_clk,
  input wire logic [1:0] lane_mode,
  input wire logic [3:0] io_out,
  output logic sck_pin,
  output logic cs_n_pin,
  output logic [3:0] io_in
);
  initial begin
    sck_pin = 1'b0;
    cs_n_pin = 1'b1;
    io_in = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one frame, msb first, bits left-aligned in v; sck stands low outside frames
  task automatic frame(input logic [55:0] v, input int nb, input int nd, input int nr,
                       output logic [7:0] rd);
    int w;
    logic [3:0] t;
    w = (lane_mode == 2'h1) ? 2 : (lane_mode == 2'h2) ? 4 : 1;
    rd = 8'h00;
    @(negedge ref_clk) cs_n_pin <= 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int c = 0; c < (nb + nr) / w + nd; c++) begin
      // released lanes toggle so a stale bit can never pass for data
      t = ~io_in;
      if (c < nb / w) begin
        if (w == 4) t = v[55:52];
        else if (w == 2) t[1:0] = v[55:54];
        else t[0] = v[55];
        v = v << w;
      end
      io_in <= t;
      repeat (8) @(negedge ref_clk);
      if (c >= nb / w + nd) begin
        if (w == 4) rd = {rd[3:0], io_out};
        else if (w == 2) rd = {rd[5:0], io_out[1:0]};
        else rd = {rd[6:0], io_out[1]};
      end
      sck_pin <= 1'b1;
      repeat (8) @(negedge ref_clk);
      sck_pin <= 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    cs_n_pin <= 1'b1;
    io_in <= ~io_in;
    repeat (8) @(negedge ref_clk);
  endtask : frame
endmodule : spi_host_model

// *** verif/tb_ecc_crc_cmd_unit.sv ***
`timescale 1ns/10ps
module tb_ecc_crc_cmd_unit;
  import ecc_crc_pkg::*;
  logic ref_clk, reset, sck_pin, cs_n_pin, dpd_active, err_detect, unit_query_err;
  logic mem_rd_en, work_in_progress, checksum_abort_bit, checksum_suspended_bit;
  logic [3:0] io_in, io_out, io_oe_n, memory_latency_code;
  logic [1:0] lane_mode;
  logic [23:0] err_unit_addr, a;
  logic [20:0] unit_query_addr, mem_rd_addr, bad_unit;
  logic [31:0] mem_rd_data, first_error_address, checksum_result_reg, rng, q, s, e;
  logic [15:0] error_detect_count;
  logic [7:0] ecc_status_reg, rd;
  int miscompares = 0;
  int n_compared = 0;
  int lat;

  ecc_crc_cmd_unit ecc_crc_cmd_unit_i (.ref_clk(ref_clk), .reset(reset), .sck_pin(sck_pin),
    .cs_n_pin(cs_n_pin), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .lane_mode(lane_mode), .memory_latency_code(memory_latency_code),
    .dpd_active(dpd_active), .err_detect(err_detect), .err_unit_addr(err_unit_addr),
    .unit_query_addr(unit_query_addr), .unit_query_err(unit_query_err),
    .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .ecc_status_reg(ecc_status_reg), .error_detect_count(error_detect_count),
    .first_error_address(first_error_address), .work_in_progress(work_in_progress),
    .checksum_abort_bit(checksum_abort_bit),
    .checksum_suspended_bit(checksum_suspended_bit),
    .checksum_result_reg(checksum_result_reg));

  spi_host_model spi_host_model_i (.ref_clk(ref_clk), .lane_mode(lane_mode),
    .io_out(io_out), .sck_pin(sck_pin), .cs_n_pin(cs_n_pin), .io_in(io_in));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : next

  function automatic logic [31:0] mem_word(input logic [20:0] ad);
    return {ad[10:0], ad} ^ 32'h5A5A_0F0F;
  endfunction : mem_word

  // whole words from start while the word fits below the end address
  function automatic logic [31:0] crc_expect(input logic [31:0] sa, input logic [31:0] ea);
    logic [31:0] c, d;
    c = CRC_INIT;
    for (logic [31:0] w = sa; w + 3 <= ea; w += 4) begin
      d = mem_word(w[20:0]);
      d = {d[7:0], d[15:8], d[23:16], d[31:24]};
      for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
    end
    return c;
  endfunction : crc_expect

  // array side: read data lands before the cycle that uses it
  always @(negedge ref_clk) begin
    mem_rd_data <= mem_rd_en ? mem_word(mem_rd_addr) : ~mem_rd_data;
    unit_query_err <= (unit_query_addr === bad_unit);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_compared++;
    if (g !== ex) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  task automatic chk_ecc(input logic f, input logic [15:0] n, input logic [31:0] t);
    chk("ecc_status_reg", {27'h0, f, 4'h0}, {24'h0, ecc_status_reg});
    chk("error_detect_count", {16'h0, n}, {16'h0, error_detect_count});
    chk("first_error_address", t, first_error_address);
  endtask : chk_ecc

  task automatic hit(input logic [23:0] ad);
    err_detect = 1'b1;
    err_unit_addr = ad;
    @(negedge ref_clk);
    err_detect = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : hit

  task automatic results;
    $display("comparisons %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rng = 32'hA699;
    reset = 1'b1;
    lane_mode = 2'h0;
    memory_latency_code = 4'h0;
    dpd_active = 1'b0;
    err_detect = 1'b0;
    err_unit_addr = 24'h0;
    mem_rd_data = 32'h0;
    unit_query_err = 1'b0;
    bad_unit = 21'h0;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_ecc(1'b0, COUNT_RESET, TRAP_RESET);
    chk("checksum_result_reg", CRC_INIT, checksum_result_reg);
    for (int m = 0; m < 3; m++) begin
      lane_mode = m[1:0];
      q = next();
      a = q[23:0];
      hit(a);
      hit(~a);
      chk_ecc(1'b1, 16'h2, {8'h00, a});
      // low address bits left random on purpose; even draws aim at a neighbour unit
      q = next();
      lat = q[29:28];
      memory_latency_code = lat[3:0];
      bad_unit = {q[20:3], 3'h0} ^ (q[0] ? 21'h0 : 21'h8);
      spi_host_model_i.frame({OP_UNIT_QUERY, q[23:0], 24'h0}, 32, lat, 8, rd);
      chk("unit_query_addr", {11'h0, q[20:3], 3'h0}, {11'h0, unit_query_addr});
      chk("unit status", {28'h0, q[0], 3'h0}, {24'h0, rd});
      chk("io_oe_n", 32'hF, {28'h0, io_oe_n});
      spi_host_model_i.frame({OP_ECC_CLEAR, 48'h0}, 16, 0, 0, rd);
      chk_ecc(1'b1, 16'h2, {8'h00, a});
      spi_host_model_i.frame({OP_ECC_CLEAR, 48'h0}, 8, 0, 0, rd);
      chk_ecc(1'b0, COUNT_RESET, TRAP_RESET);
    end
    hit(a);
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_ecc(1'b0, COUNT_RESET, TRAP_RESET);
    // held high: one detection per clock, so the count saturates quickly
    err_unit_addr = 24'h00_0040;
    err_detect = 1'b1;
    repeat (65536) @(negedge ref_clk);
    err_detect = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_ecc(1'b1, COUNT_MAX, 32'h0000_0040);
    hit(24'h00_0080);
    chk_ecc(1'b1, COUNT_MAX, 32'h0000_0040);
    dpd_active = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_ecc(1'b1, COUNT_RESET, TRAP_RESET);
    dpd_active = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_ecc(1'b1, COUNT_RESET, TRAP_RESET);
    lane_mode = 2'h2;
    s = next() & 32'h000F_FFFC;
    e = s + 32'd799;
    spi_host_model_i.frame({OP_CSUM_COMPUTE, s[23:0], s[23:0] + 24'h2}, 56, 0, 0, rd);
    chk("checksum_abort_bit", 32'h1, {31'h0, checksum_abort_bit});
    chk("work_in_progress", 32'h0, {31'h0, work_in_progress});
    spi_host_model_i.frame({OP_CSUM_COMPUTE, s[23:0], e[23:0]}, 56, 0, 0, rd);
    chk("work_in_progress", 32'h1, {31'h0, work_in_progress});
    chk("checksum_abort_bit", 32'h0, {31'h0, checksum_abort_bit});
    lane_mode = 2'h1;
    spi_host_model_i.frame({OP_CSUM_SUSPEND, 48'h0}, 8, 0, 0, rd);
    chk("checksum_suspended_bit", 32'h1, {31'h0, checksum_suspended_bit});
    chk("work_in_progress", 32'h0, {31'h0, work_in_progress});
    lane_mode = 2'h0;
    spi_host_model_i.frame({OP_CSUM_RESUME, 48'h0}, 8, 0, 0, rd);
    chk("checksum_suspended_bit", 32'h0, {31'h0, checksum_suspended_bit});
    for (lat = 0; lat < 3000 && work_in_progress !== 1'b0; lat++) @(negedge ref_clk);
    if (lat == 3000) begin
      miscompares++;
      results();
    end
    chk("checksum_result_reg", crc_expect(s, e), checksum_result_reg);
    spi_host_model_i.frame({OP_CSUM_RESUME, 48'h0}, 8, 0, 0, rd);
    chk("work_in_progress", 32'h0, {31'h0, work_in_progress});
    results();
  end
endmodule : tb_ecc_crc_cmd_unit
